// ===== src/run_cmd_pkg.sv
// Package: register map, field layout and encodings for run commands
package run_cmd_pkg;
    localparam int ADDR_W = 8;
    localparam int POS_W = 32;
    localparam int NODE_W = 6;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_INC_DIST = 8'h08;
    localparam logic [7:0] OFS_OFFSET_TGT = 8'h0C;
    localparam logic [7:0] OFS_OFFSET_REF = 8'h10;
    localparam logic [7:0] OFS_REMOTE = 8'h14;
    localparam logic [7:0] OFS_PROFILE = 8'h18;
    localparam logic [7:0] OFS_POSITION = 8'h1C;
    localparam logic [7:0] OFS_TARGET = 8'h20;
    localparam logic [7:0] OFS_NET_LAST = 8'h24;
    localparam logic [7:0] OFS_INDEX_POS = 8'h28;
    // Control register bits (bits 0 to 2: write 1 to issue)
    localparam int CTRL_RUN_INC = 0;
    localparam int CTRL_RUN_OFS = 1;
    localparam int CTRL_RUN_NET = 2;
    localparam int CTRL_IMMEDIATE = 3;
    localparam int CTRL_DNET = 4;
    localparam int CTRL_BLOCK = 5;
    localparam int CTRL_INDEX_IN_EN = 6;
    localparam int CTRL_INDEX_AUX_EN = 7;
    localparam int CTRL_NODE_VAR = 8;
    localparam int CTRL_NODE_LSB = 16;
    // Remote register fields
    localparam int REM_MODE_LSB = 0;
    localparam int REM_INC = 2;
    localparam int REM_DIR = 3;
    localparam int REM_VAR_LSB = 8;
    // Status bits
    localparam int ST_IN_POS = 0;
    localparam int ST_BUSY = 1;
    localparam int ST_REJECT = 2;
    localparam int ST_NET_BUSY = 3;
    localparam int ST_MT_LSB = 4;
    // Network object attribute written by the profile command
    localparam logic [7:0] NET_ATTR_PROFILE = 8'h0B;
    localparam logic [5:0] NODE_MAX = 6'h3F;
    // Motion types
    localparam logic [1:0] MT_VEL = 2'h0;
    localparam logic [1:0] MT_TIME = 2'h1;
    localparam logic [1:0] MT_PULSE = 2'h2;
    // Remote profile codes sent to the node
    typedef enum logic [2:0] {
        PROF_ABS = 3'h0,
        PROF_INC = 3'h1,
        PROF_VEL_FWD = 3'h2,
        PROF_VEL_REV = 3'h3,
        PROF_TORQUE = 3'h4,
        PROF_NONE = 3'h7
    } profile_t;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] REMOTE_RESET = 32'h0000_0000;
    localparam logic [31:0] PROFILE_RESET = 32'h0000_0000;
endpackage

// ===== src/motion_if.sv
// Interface: move request from the command logic to the axis stepper
interface motion_if #(parameter int POS_W = 32);
    logic start;
    logic [POS_W-1:0] target;
    logic [1:0] motion_type;
    logic [31:0] profile_word;
    logic busy;
    logic [POS_W-1:0] position;
    modport cmd (output start, target, motion_type, profile_word,
                 input busy, position);
    modport axis (input start, target, motion_type, profile_word,
                  output busy, position);
endinterface

// ===== src/axis_stepper.sv
// Axis stepper: walks the position toward the target one unit per step tick
module axis_stepper (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic step_en_i,
    motion_if.axis mv
);
    import run_cmd_pkg::*;

    logic [POS_W-1:0] goal_reg;

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            goal_reg <= '0;
        end else if (mv.start) begin
            goal_reg <= mv.target;
        end
    end

    // A new start simply retargets, so a moving axis needs no stop first
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            mv.position <= '0;
        end else if (step_en_i && !mv.start && mv.position != goal_reg) begin
            if ($signed(goal_reg - mv.position) > 0) begin
                mv.position <= mv.position + 1'b1;
            end else begin
                mv.position <= mv.position - 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            mv.busy <= 1'b0;
        end else begin
            mv.busy <= mv.start ||
                (mv.busy && mv.position != goal_reg);
        end
    end
endmodule // axis_stepper

// ===== src/step_divider.sv
// Step divider: one-cycle enable pulse every DIV clock cycles
module step_divider #(
    parameter int DIV = 4
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    output logic tick_o
);
    logic [15:0] cnt_reg;

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            cnt_reg <= '0;
            tick_o <= 1'b0;
        end else if (cnt_reg == 16'(DIV - 1)) begin
            cnt_reg <= '0;
            tick_o <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 16'h0001;
            tick_o <= 1'b0;
        end
    end
endmodule // step_divider

// ===== src/axis_position_run_commands.sv
// Run-command interpreter: incremental, offset and network profile runs
// Overview of operation
// - Incremental target is position plus distance
// - New run replaces active run unless blocked
// - Offset run goes to offset target plus reference
// - Network command writes attribute 11 at node
// - Reject network command immediate over DeviceNet
// - Remote profile chosen by mode and flags
// - Velocity type uses velocity parameter set (the axis stepper here ignores motion_type and profile_word)
// - Time type uses time parameter set (the axis stepper here ignores motion_type and profile_word)
// - Pulse type uses pulse parameter set (the axis stepper here ignores motion_type and profile_word)
// - Incremental run doubles as index move
//
// Local design decisions: the Wishbone slave port and the placing of the registers.
module axis_position_run_commands #(
    parameter int STEP_DIV = 4
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [run_cmd_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic index_input_i,
    input wire logic [run_cmd_pkg::POS_W-1:0] aux_position_i,
    output logic net_req_o,
    output logic [run_cmd_pkg::NODE_W-1:0] net_node_o,
    output logic [7:0] net_attr_o,
    output logic [2:0] net_profile_o,
    input wire logic net_done_i,
    output logic in_position_o,
    output logic [run_cmd_pkg::POS_W-1:0] axis_position_o
);
    import run_cmd_pkg::*;

    typedef enum logic [2:0] {
        NET_IDLE = 3'b001,
        NET_SEND = 3'b010,
        NET_WAIT = 3'b100
    } net_state_t;

    logic [31:0] ctrl_reg;
    logic [31:0] inc_dist_reg;
    logic [31:0] offset_tgt_reg;
    logic [31:0] offset_ref_reg;
    logic [31:0] remote_reg;
    logic [31:0] profile_reg;
    logic [31:0] index_pos_reg;
    logic [31:0] node_var_reg;
    logic reject_reg;
    logic pend_valid_reg;
    logic [POS_W-1:0] pend_target_reg;
    net_state_t net_state_reg;
    logic [2:0] net_prof_reg;
    logic [NODE_W-1:0] net_node_reg;
    logic [1:0] index_sync_reg;
    logic index_prev_reg;
    logic aux_armed_reg;
    logic tick;
    logic [31:0] rd_data;
    logic [31:0] wmask;
    logic [31:0] wr_word;
    logic wr_ctrl;
    logic issue_inc;
    logic issue_ofs;
    logic issue_net;
    logic index_fire;
    logic aux_fire;
    logic net_ok;
    logic [1:0] mt;
    logic [POS_W-1:0] cur_pos;

    motion_if #(.POS_W(POS_W)) mv ();

    step_divider #(.DIV(STEP_DIV)) u_div (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .tick_o(tick)
    );

    axis_stepper u_axis (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .step_en_i(tick),
        .mv(mv)
    );

    assign cur_pos = mv.position;
    assign mt = profile_reg[1:0];

    // Byte-lane write mask
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{wb_sel_i[i]}};
        end
    end

    logic wr_stb;
    assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign wr_ctrl = wr_stb && wb_adr_i == OFS_CTRL;
    assign wr_word = wb_dat_i & wmask;

    // Command strobes come from control writes, plus index and aux triggers for the incremental run; run bits are self clearing
    assign issue_inc = (wr_ctrl && wr_word[CTRL_RUN_INC]) || index_fire
        || aux_fire;
    assign issue_ofs = wr_ctrl && wr_word[CTRL_RUN_OFS];
    assign issue_net = wr_ctrl && wr_word[CTRL_RUN_NET];

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg <= (ctrl_reg & ~wmask) | (wr_word & 32'hFFFF_FFF8);
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old);
        merge = (old & ~wmask) | wr_word;
    endfunction

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            inc_dist_reg <= '0;
            offset_tgt_reg <= '0;
            offset_ref_reg <= '0;
            remote_reg <= REMOTE_RESET;
            profile_reg <= PROFILE_RESET;
            index_pos_reg <= '0;
            node_var_reg <= '0;
        end else if (wr_stb) begin
            case (wb_adr_i)
                OFS_INC_DIST: inc_dist_reg <= merge(inc_dist_reg);
                OFS_OFFSET_TGT: offset_tgt_reg <= merge(offset_tgt_reg);
                OFS_OFFSET_REF: offset_ref_reg <= merge(offset_ref_reg);
                OFS_REMOTE: remote_reg <= merge(remote_reg);
                OFS_PROFILE: profile_reg <= merge(profile_reg);
                OFS_INDEX_POS: index_pos_reg <= merge(index_pos_reg);
                OFS_NET_LAST: node_var_reg <= merge(node_var_reg);
                default: ;
            endcase
        end
    end

    // Index input passes two flops before the edge detector
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            index_sync_reg <= 2'b00;
            index_prev_reg <= 1'b0;
        end else begin
            index_sync_reg <= {index_sync_reg[0], index_input_i};
            index_prev_reg <= index_sync_reg[1];
        end
    end

    assign index_fire = ctrl_reg[CTRL_INDEX_IN_EN] && index_sync_reg[1]
        && !index_prev_reg;
    assign aux_fire = ctrl_reg[CTRL_INDEX_AUX_EN] && aux_armed_reg
        && aux_position_i == index_pos_reg;

    // Auxiliary trigger fires once per arming to avoid repeated moves
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            aux_armed_reg <= 1'b0;
        end else if (aux_fire) begin
            aux_armed_reg <= 1'b0;
        end else if (aux_position_i != index_pos_reg) begin
            aux_armed_reg <= 1'b1;
        end
    end

    // Pending target and start toward the axis
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            mv.start <= 1'b0;
            mv.target <= '0;
            pend_valid_reg <= 1'b0;
            pend_target_reg <= '0;
        end else begin
            mv.start <= 1'b0;
            if (issue_inc || issue_ofs) begin
                pend_target_reg <= issue_inc ? cur_pos + inc_dist_reg
                    : offset_tgt_reg + offset_ref_reg;
                if (ctrl_reg[CTRL_BLOCK] && mv.busy) begin
                    pend_valid_reg <= 1'b1;
                end else begin
                    mv.start <= 1'b1;
                    mv.target <= issue_inc ? cur_pos + inc_dist_reg
                        : offset_tgt_reg + offset_ref_reg;
                end
            end else if (pend_valid_reg && !mv.busy && !mv.start) begin
                // Motion block: queued run starts after the current one
                mv.start <= 1'b1;
                mv.target <= pend_target_reg;
                pend_valid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            mv.motion_type <= MT_VEL;
            mv.profile_word <= '0;
        end else if (issue_inc || issue_ofs) begin
            mv.motion_type <= mt;
            mv.profile_word <= profile_reg;
        end
    end

    // The mode bits may come in the same write as the run bit, so the
    // written value is judged as well as the stored one.
    // immediate over DeviceNet refused
    assign net_ok = !(ctrl_reg[CTRL_IMMEDIATE] && ctrl_reg[CTRL_DNET]
        && !(wr_ctrl && wmask[CTRL_IMMEDIATE]))
        && !(wr_ctrl && wmask[CTRL_IMMEDIATE] && wr_word[CTRL_IMMEDIATE]
        && (wmask[CTRL_DNET] ? wr_word[CTRL_DNET] : ctrl_reg[CTRL_DNET]));

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            reject_reg <= 1'b0;
        end else if (issue_net && !net_ok) begin
            reject_reg <= 1'b1;
        end else if (issue_net || issue_inc || issue_ofs) begin
            reject_reg <= 1'b0;
        end
    end

    function automatic logic [2:0] pick_profile(input logic [31:0] r);
        case (r[REM_MODE_LSB +: 2])
            2'h0: pick_profile = r[REM_INC] ? PROF_INC : PROF_ABS;
            2'h1: pick_profile = r[REM_DIR] ? PROF_VEL_FWD : PROF_VEL_REV;
            2'h2: pick_profile = PROF_TORQUE;
            default: pick_profile = PROF_NONE;
        endcase
    endfunction

    // Only one network write is in flight; a network command that arrives
    // before the node answers is dropped rather than queued.
    // node and attribute
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            net_state_reg <= NET_IDLE;
            net_prof_reg <= PROF_NONE;
            net_node_reg <= '0;
        end else begin
            case (net_state_reg)
                NET_IDLE: begin
                    if (issue_net && net_ok) begin
                        net_prof_reg <= pick_profile(remote_reg);
                        net_node_reg <= wr_word[CTRL_NODE_VAR]
                            ? node_var_reg[NODE_W-1:0] & NODE_MAX
                            : wr_word[CTRL_NODE_LSB +: NODE_W];
                        net_state_reg <= NET_SEND;
                    end
                end
                NET_SEND: net_state_reg <= NET_WAIT;
                NET_WAIT: begin
                    if (net_done_i) begin
                        net_state_reg <= NET_IDLE;
                    end
                end
                default: net_state_reg <= NET_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            net_req_o <= 1'b0;
            net_node_o <= '0;
            net_attr_o <= '0;
            net_profile_o <= PROF_NONE;
        end else begin
            net_req_o <= net_state_reg == NET_SEND;
            if (net_state_reg == NET_SEND) begin
                net_node_o <= net_node_reg;
                net_attr_o <= NET_ATTR_PROFILE;
                net_profile_o <= net_prof_reg;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            in_position_o <= 1'b1;
        end else begin
            in_position_o <= !(mv.busy || mv.start || pend_valid_reg
                || issue_inc || issue_ofs);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            axis_position_o <= '0;
        end else begin
            axis_position_o <= cur_pos;
        end
    end

    // Status packs in-position, busy, reject, network busy, motion type.
    // Reads are combinational here and registered once at the ack edge.
    always_comb begin
        case (wb_adr_i)
            OFS_CTRL: rd_data = ctrl_reg;
            OFS_STATUS: rd_data = 32'({mt, net_state_reg != NET_IDLE,
                reject_reg, mv.busy, in_position_o}) |
                32'(0 * ST_MT_LSB);
            OFS_INC_DIST: rd_data = inc_dist_reg;
            OFS_OFFSET_TGT: rd_data = offset_tgt_reg;
            OFS_OFFSET_REF: rd_data = offset_ref_reg;
            OFS_REMOTE: rd_data = remote_reg;
            OFS_PROFILE: rd_data = profile_reg;
            OFS_POSITION: rd_data = cur_pos;
            OFS_TARGET: rd_data = mv.target;
            OFS_NET_LAST: rd_data = node_var_reg;
            OFS_INDEX_POS: rd_data = index_pos_reg;
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // Single-wait-state slave: ack one cycle after the strobe
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o <= rd_data;
        end
    end
endmodule // axis_position_run_commands

// ===== tb/axis_position_run_commands_props.sv
// Checker: bus, network and motion relations at the run-command ports
module axis_position_run_commands_props
    import run_cmd_pkg::*;
#(
    parameter int STEP_DIV = 4
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic index_input_i,
    input wire logic [POS_W-1:0] aux_position_i,
    input wire logic net_req_o,
    input wire logic [NODE_W-1:0] net_node_o,
    input wire logic [7:0] net_attr_o,
    input wire logic [2:0] net_profile_o,
    input wire logic net_done_i,
    input wire logic in_position_o,
    input wire logic [POS_W-1:0] axis_position_o
);
    logic ctrl_wr;
    assign ctrl_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
        && wb_adr_i == OFS_CTRL && wb_sel_i[0];
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_net_ok;
        ctrl_wr && wb_dat_i[2] && !(wb_dat_i[3] && wb_dat_i[4]);
    endsequence
    sequence s_net_bad;
        ctrl_wr && wb_dat_i[2] && wb_dat_i[3] && wb_dat_i[4];
    endsequence
    sequence s_run;
        ctrl_wr && (wb_dat_i[0] || wb_dat_i[1]) && !wb_dat_i[5];
    endsequence
    property p_ack;
        s_take |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    property p_net_lat;
        s_net_ok |-> ##[1:3] net_req_o;
    endproperty
    property p_req_pulse;
        net_req_o |=> !net_req_o;
    endproperty
    property p_attr;
        net_req_o |-> net_attr_o == NET_ATTR_PROFILE;
    endproperty
    property p_prof;
        net_req_o |-> net_profile_o != PROF_NONE;
    endproperty
    property p_reject;
        s_net_bad |-> ##1 !net_req_o [*4];
    endproperty
    property p_step;
        1'b1 |=> (axis_position_o - $past(axis_position_o))
            inside {32'h0000_0000, 32'h0000_0001, 32'hFFFF_FFFF};
    endproperty
    property p_hold;
        in_position_o && $past(in_position_o) |-> $stable(axis_position_o);
    endproperty
    property p_run_busy;
        s_run |-> ##[1:4] !in_position_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack not one cycle");
    a_net_lat: assert property (p_net_lat) else $error("no net request");
    a_req_pulse: assert property (p_req_pulse) else $error("long request");
    a_attr: assert property (p_attr) else $error("wrong attribute");
    a_prof: assert property (p_prof) else $error("bad profile code");
    a_reject: assert property (p_reject) else $error("not rejected");
    a_step: assert property (p_step) else $error("position jump");
    a_hold: assert property (p_hold) else $error("moved in position");
    a_run_busy: assert property (p_run_busy) else $error("still idle");
endmodule // axis_position_run_commands_props

bind axis_position_run_commands axis_position_run_commands_props #(
    .STEP_DIV(STEP_DIV)
) i_axis_position_run_commands_props (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .index_input_i(index_input_i),
    .aux_position_i(aux_position_i), .net_req_o(net_req_o),
    .net_node_o(net_node_o), .net_attr_o(net_attr_o),
    .net_profile_o(net_profile_o), .net_done_i(net_done_i),
    .in_position_o(in_position_o), .axis_position_o(axis_position_o)
);

// ===== tb/remote_node_model.sv
// Remote node model: takes attribute writes, answers promptly or slowly
module remote_node_model
    import run_cmd_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic net_req_i,
    input wire logic [7:0] net_attr_i,
    output logic net_done_o,
    output logic [7:0] req_count_o
);
    logic [3:0] wait_reg;
    logic slow_reg;
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            wait_reg <= 4'h0;
            slow_reg <= 1'b0;
            net_done_o <= 1'b0;
            req_count_o <= 8'h00;
        end else begin
            net_done_o <= 1'b0;
            if (net_req_i && net_attr_i == NET_ATTR_PROFILE) begin
                wait_reg <= slow_reg ? 4'hC : 4'h1;
                slow_reg <= !slow_reg;
                req_count_o <= req_count_o + 8'h01;
            end else if (wait_reg == 4'h1) begin
                net_done_o <= 1'b1;
                wait_reg <= 4'h0;
            end else if (wait_reg != 4'h0) begin
                wait_reg <= wait_reg - 4'h1;
            end
        end
    end
endmodule // remote_node_model

// ===== tb/axis_position_run_commands_bench.sv
// Bench: random and corner runs through the register bus and network port
module axis_position_run_commands_bench
    import run_cmd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_i, sys_rst_i, cyc, stb, we, ack, idx, req, done, in_pos;
    logic [7:0] adr, attr, reqs, c;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, aux, pos, exp_pos, rd, d, t, r, ctl;
    logic [5:0] node, nd;
    logic [2:0] prof;
    logic [1:0] md;
    int fail_count, cmp_count;
    axis_position_run_commands #(.STEP_DIV(2)) i_axis_position_run_commands (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .index_input_i(idx), .aux_position_i(aux), .net_req_o(req),
        .net_node_o(node), .net_attr_o(attr), .net_profile_o(prof),
        .net_done_i(done), .in_position_o(in_pos), .axis_position_o(pos));
    remote_node_model i_remote_node_model (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .net_req_i(req),
        .net_attr_i(attr), .net_done_o(done), .req_count_o(reqs));
    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    task automatic final_report();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_hi(ref logic s, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (s !== 1'b1 && n < lim);
        if (s !== 1'b1) fail_count++;
    endtask
    // Holds the request until the ack edge, then releases for a cycle
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] v);
        @(posedge ref_clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= v;
        wait_hi(ack, 50);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic settle();
        repeat (4) @(posedge ref_clk_i);
        wait_hi(in_pos, 3000);
    endtask
    function automatic logic [2:0] exp_prof(logic [1:0] m, logic i, logic dr);
        if (m == 2'h0) return i ? 3'h1 : 3'h0;
        if (m == 2'h1) return dr ? 3'h2 : 3'h3;
        return 3'h4;
    endfunction
    initial begin
        #2_000_000;
        fail_count++;
        final_report();
    end
    initial begin
        void'($urandom(58170));
        {sys_rst_i, cyc, stb, we, idx, sel} = {1'b1, 4'h0, 4'hF};
        {adr, wdat, aux} = '0;
        repeat (4) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        check(in_pos, 1);
        bus(8'hFC, 0, 0);
        check(rd, 0);
        exp_pos = 0;
        for (int m = 0; m < 3; m++) begin
            d = 8 + $urandom % 20;
            bus(OFS_PROFILE, 1, m);
            bus(OFS_STATUS, 0, 0);
            check(rd[5:4], m);
            bus(OFS_INC_DIST, 1, d);
            bus(OFS_CTRL, 1, 32'h0000_0001);
            repeat (3) @(posedge ref_clk_i);
            check(in_pos, 0);
            settle();
            exp_pos = exp_pos + d;
            check(pos, exp_pos);
        end
        t = 100 + $urandom % 30;
        r = $urandom % 30;
        bus(OFS_INC_DIST, 1, 200);
        bus(OFS_CTRL, 1, 32'h0000_0001);
        bus(OFS_OFFSET_TGT, 1, t);
        bus(OFS_OFFSET_REF, 1, r);
        bus(OFS_CTRL, 1, 32'h0000_0002);
        settle();
        exp_pos = t + r;
        check(pos, exp_pos);
        // Motion block: the run issued while busy must queue, not retarget
        bus(OFS_INC_DIST, 1, 60);
        bus(OFS_CTRL, 1, 32'h0000_0021);
        bus(OFS_OFFSET_REF, 1, 0);
        bus(OFS_CTRL, 1, 32'h0000_0022);
        bus(OFS_TARGET, 0, 0);
        check(rd, exp_pos + 60);
        settle();
        exp_pos = t;
        check(pos, exp_pos);
        d = 8 + $urandom % 10;
        bus(OFS_INC_DIST, 1, d);
        bus(OFS_CTRL, 1, 32'h0000_0040);
        @(posedge ref_clk_i) idx <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        idx <= 1'b0;
        settle();
        exp_pos = exp_pos + d;
        check(pos, exp_pos);
        t = 32'h0000_1000 + $urandom % 256;
        bus(OFS_INDEX_POS, 1, t);
        bus(OFS_CTRL, 1, 32'h0000_0080);
        @(posedge ref_clk_i) aux <= t;
        @(posedge ref_clk_i) aux <= 32'h0000_0000;
        settle();
        exp_pos = exp_pos + d;
        check(pos, exp_pos);
        bus(OFS_CTRL, 1, 32'h0000_0000);
        for (int k = 0; k < 12; k++) begin
            md = 2'(k >> 2);
            nd = (k == 0) ? 6'h00 : (k == 11) ? 6'h3F : 6'($urandom % 64);
            bus(OFS_REMOTE, 1, {28'h0, k[1], k[0], md});
            ctl = {10'h0, nd, 16'h0004};
            if ($urandom % 2) begin
                bus(OFS_NET_LAST, 1, {26'h0, nd});
                ctl = 32'h0000_0104;
            end
            bus(OFS_CTRL, 1, ctl);
            wait_hi(req, 20);
            check(node, nd);
            check(attr, 8'h0B);
            check(prof, exp_prof(md, k[0], k[1]));
            wait_hi(done, 40);
            @(posedge ref_clk_i);
        end
        c = reqs;
        bus(OFS_CTRL, 1, 32'h0000_001C);
        repeat (8) @(posedge ref_clk_i);
        check(reqs, c);
        bus(OFS_STATUS, 0, 0);
        check(rd[2], 1);
        final_report();
    end
endmodule // axis_position_run_commands_bench
